// *** crp_channel_model.sv ***
`timescale 1ns/1ps
module crp_channel_model
	import crp_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic [WORD_W-1:0] i_a,
	input  wire logic              i_reply,
	input  wire logic              i_reject,
	output logic [WORD_W-1:0]      o_q,
	output logic [WORD_W-1:0]      o_a,
	output logic                   o_read,
	output logic                   o_write,
	output logic                   o_prot
);
	logic [1:0]        resp;
	logic [WORD_W-1:0] data;

	initial begin
		o_q = ZERO_W;
		o_a = ZERO_W;
		o_read = 1'b0;
		o_write = 1'b0;
		o_prot = 1'b0;
	end

	// one instruction: words settle first, strobe held until answered or 20 cycles pass
	task automatic xfer(input logic rd, input logic [WORD_W-1:0] q, input logic [WORD_W-1:0] a, input logic prot);
		int n;
		n = 0;
		@(negedge i_clk);
		o_q = q;
		o_a = a;
		o_prot = prot;
		repeat (3) @(negedge i_clk);
		o_read = rd;
		o_write = !rd;
		resp = 2'h0;
		while (resp == 2'h0 && n < 20) begin
			@(posedge i_clk);
			n++;
			if (i_reply || i_reject) begin
				resp = {i_reject, i_reply};
				data = i_a;
			end
		end
		@(negedge i_clk);
		o_read = 1'b0;
		o_write = 1'b0;
		// released lines show garbage, not the old word
		o_q = ~q;
		o_a = ~a;
		o_prot = ~prot;
		repeat (2) @(negedge i_clk);
	endtask : xfer
endmodule : crp_channel_model

// *** crp_channel_port.sv ***
`timescale 1ns/1ps
module crp_channel_port
	import crp_pkg::*;
#(
	parameter int unsigned COLS = LAST_COL
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [WORD_W-1:0] i_q,
	input  wire logic [WORD_W-1:0] i_a,
	input  wire logic              i_read,
	input  wire logic              i_write,
	input  wire logic              i_prot,
	input  wire logic [3:0]        i_equip_sw,
	input  wire crp_panel_s        i_panel,
	input  wire crp_station_s      i_station,
	output logic [WORD_W-1:0]      o_a,
	output logic                   o_reply,
	output logic                   o_reject,
	output logic                   o_interrupt,
	output logic                   o_feed,
	output logic                   o_offset
);
	// pin-side inputs pass two flops
	logic [WORD_W-1:0] q_s1, q_s2, a_s1, a_s2;
	logic rd_s1, rd_s2, wr_s1, wr_s2, pr_s1, pr_s2, rd_s3, wr_s3;
	logic [3:0] eq_s1, eq_s2;
	crp_panel_s pn_s1, pn_s2;
	crp_station_s st_s1, st_s2;
	logic colstb_q, rdysw_q;

	always_ff @(posedge i_clk) begin
		q_s1  <= i_q;
		q_s2  <= q_s1;
		a_s1  <= i_a;
		a_s2  <= a_s1;
		eq_s1 <= i_equip_sw;
		eq_s2 <= eq_s1;
		pn_s1 <= i_panel;
		pn_s2 <= pn_s1;
		st_s1 <= i_station;
		st_s2 <= st_s1;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_s1 <= 1'b0;
			rd_s2 <= 1'b0;
			rd_s3 <= 1'b0;
			wr_s1 <= 1'b0;
			wr_s2 <= 1'b0;
			wr_s3 <= 1'b0;
			pr_s1 <= 1'b0;
			pr_s2 <= 1'b0;
			colstb_q <= 1'b0;
			rdysw_q <= 1'b0;
		end else begin
			rd_s1 <= i_read;
			rd_s2 <= rd_s1;
			rd_s3 <= rd_s2;
			wr_s1 <= i_write;
			wr_s2 <= wr_s1;
			wr_s3 <= wr_s2;
			pr_s1 <= i_prot;
			pr_s2 <= pr_s1;
			colstb_q <= st_s2.col_strobe;
			rdysw_q <= pn_s2.ready_sw;
		end
	end

	// strobe rising edges, one access per strobe
	wire rd_go  = rd_s2 & ~rd_s3;
	wire wr_go  = wr_s2 & ~wr_s3;
	wire col_go = st_s2.col_strobe & ~colstb_q;
	wire sw_go  = pn_s2.ready_sw & ~rdysw_q;

	function automatic logic field_zero(input logic [WORD_W-1:0] w, input int unsigned lo, input int unsigned hi);
		logic z;
		z = 1'b1;
		for (int unsigned i = 0; i < WORD_W; i++) begin
			if (i >= lo && i <= hi && w[i])
				z = 1'b0;
		end
		return z;
	endfunction : field_zero

	wire conv_ok  = field_zero(q_s2, Q_CV_LO, Q_CV_HI); // R01
	wire eq_ok    = (q_s2[Q_EQ_HI:Q_EQ_LO] == eq_s2); // R02
	wire sta_ok   = q_s2[Q_STA5] & ~q_s2[Q_STA6];
	wire addr_ok  = conv_ok & eq_ok & sta_ok;
	wire prot_ok  = ~pn_s2.protect_sw | pr_s2; // R20
	wire is_data  = ~q_s2[Q_DIR0] & ~q_s2[Q_DIR1]; // R03
	wire is_stat  = q_s2[Q_DIR0]; // R14
	wire is_func  = q_s2[Q_DIR0] & ~q_s2[Q_DIR1]; // R05
	wire act_zero = field_zero(a_s2, F_ACT_LO, F_ACT_HI);

	// ready and alarm
	logic ready_q, lost_q, prerr_q, data_q, eop_q, dati_q, eopi_q, almi_q, almr_q, eopr_q;
	logic [COL_W-1:0] col_q;
	logic [6:0] colcnt_q;
	crp_state_e state_q;

	wire rdy_cond   = pn_s2.power_ok & (~pn_s2.hopper_empty | pn_s2.end_of_file) & ~pn_s2.stacker_full
	                & ~pn_s2.jam & ~pn_s2.lid_open; // R16
	wire feed_alert = pn_s2.fail_feed | pn_s2.read_jam | pn_s2.post_jam | pn_s2.stack_jam; // R21
	wire alarm      = pn_s2.hopper_empty | pn_s2.stacker_full | feed_alert | pn_s2.lid_open
	                | lost_q | prerr_q; // R21 R23
	wire busy       = (state_q == CRP_READ); // R17

	wire rd_acc  = rd_go & addr_ok & prot_ok;
	wire wr_acc  = wr_go & addr_ok & prot_ok & is_func & (ready_q | act_zero); // R06
	wire dat_acc = rd_acc & is_data & ready_q & data_q; // R04
	wire sts_acc = rd_acc & is_stat;
	wire f_clr   = wr_acc & a_s2[F_CLR];
	wire f_clri  = wr_acc & a_s2[F_CLRI];
	wire f_feed  = wr_acc & a_s2[F_FEED] & ready_q; // R12
	wire f_ofst  = wr_acc & a_s2[F_OFST]; // R13
	wire col_in  = col_go & busy;
	wire overrun = col_in & data_q & ~dat_acc; // R19
	wire card_end = col_in & (colcnt_q == 7'(COLS)); // R24
	wire op_end  = (card_end | overrun) & busy;
	wire prechk  = (st_s2.light_check & (st_s2.amp != {COL_W{1'b1}}))
	             | (st_s2.dark_check & (st_s2.amp != {COL_W{1'b0}})); // R22

	always_ff @(posedge i_clk) begin
		if (i_rst)
			ready_q <= 1'b0;
		else if (!rdy_cond || (sw_go && ready_q))
			ready_q <= 1'b0; // R16
		else if (sw_go)
			ready_q <= 1'b1;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q  <= CRP_IDLE;
			colcnt_q <= 7'h00;
		end else begin
			case (state_q)
				CRP_IDLE, CRP_DONE: begin
					if (f_feed) begin
						state_q  <= CRP_READ; // R17
						colcnt_q <= 7'h00;
					end
				end
				CRP_READ: begin
					if (f_feed) begin
						colcnt_q <= 7'h00; // R24
					end else if (op_end) begin
						state_q <= CRP_DONE; // R19
					end else if (col_in) begin
						colcnt_q <= colcnt_q + 7'h01;
					end
				end
				default: state_q <= CRP_IDLE;
			endcase
		end
	end

	// column register: only columns 1..COLS are data
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			data_q <= 1'b0;
			col_q  <= '0;
		end else if (f_clr || f_feed || op_end) begin
			data_q <= 1'b0; // R04
		end else if (col_in && (colcnt_q < 7'(COLS))) begin
			data_q <= 1'b1; // R18
			col_q  <= st_s2.col_data;
		end else if (dat_acc) begin
			data_q <= 1'b0; // R18
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lost_q  <= 1'b0;
			prerr_q <= 1'b0;
			eop_q   <= 1'b0;
		end else begin
			if (overrun && busy)
				lost_q <= 1'b1; // R19
			else if (f_clr)
				lost_q <= 1'b0;
			if (busy && prechk)
				prerr_q <= 1'b1; // R22
			else if (f_clr)
				prerr_q <= 1'b0; // R23
			if (op_end)
				eop_q <= 1'b1;
			else if (f_clr || f_feed)
				eop_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dati_q <= 1'b0;
			eopi_q <= 1'b0;
			eopr_q <= 1'b0;
			almi_q <= 1'b0;
			almr_q <= 1'b0;
		end else begin
			if (wr_acc && a_s2[F_DATI])
				dati_q <= 1'b1; // R07 R08
			else if (f_clr || f_clri)
				dati_q <= 1'b0;
			if (wr_acc && a_s2[F_EOPI])
				eopi_q <= 1'b1; // R07 R09
			else if (f_clr || f_clri)
				eopi_q <= 1'b0;
			if (op_end && (eopi_q || (wr_acc && a_s2[F_EOPI])))
				eopr_q <= 1'b1; // R09
			else if (f_clr || f_clri)
				eopr_q <= 1'b0;
			if (wr_acc && a_s2[F_ALMI])
				almi_q <= 1'b1; // R11
			else if (f_clr || f_clri)
				almi_q <= 1'b0; // R11
			if (((almi_q && !(f_clr || f_clri)) || (wr_acc && a_s2[F_ALMI])) && alarm)
				almr_q <= 1'b1; // R10
			else if (f_clr || f_clri)
				almr_q <= 1'b0; // R11
		end
	end

	wire dat_irq = dati_q & data_q; // R08
	wire irq     = dat_irq | eopr_q | almr_q;

	wire [WORD_W-1:0] stat1 = {5'b00000, pn_s2.end_of_file, feed_alert, prerr_q, pn_s2.protect_sw,
	                           lost_q, alarm, eop_q, data_q, irq, busy, ready_q}; // R15
	wire [WORD_W-1:0] stat2 = {5'b00000, pn_s2.door_open, 1'b0, pn_s2.manual, 1'b0, prerr_q,
	                           pn_s2.stack_jam, pn_s2.post_jam, pn_s2.read_jam, pn_s2.fail_feed,
	                           pn_s2.stacker_full, pn_s2.hopper_empty}; // R14
	wire [WORD_W-1:0] rd_word = is_stat ? (q_s2[Q_DIR1] ? stat2 : stat1)
	                                    : {{(WORD_W-COL_W){1'b0}}, col_q}; // R03
	wire addressed = (rd_go | wr_go) & conv_ok & eq_ok;
	wire accepted  = dat_acc | sts_acc | wr_acc;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_a         <= ZERO_W;
			o_reply     <= 1'b0;
			o_reject    <= 1'b0;
			o_interrupt <= 1'b0;
			o_feed      <= 1'b0;
			o_offset    <= 1'b0;
		end else begin
			if (dat_acc || sts_acc)
				o_a <= rd_word;
			o_reply     <= accepted; // R25
			o_reject    <= addressed & ~accepted; // R25
			o_interrupt <= irq;
			o_feed      <= f_feed;
			o_offset    <= f_ofst;
		end
	end

	a_conv_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
		((rd_go || wr_go) && !conv_ok) |=> !o_reply && !o_reject) else $error("converter field not ignored"); // R01
	a_equip_match: assert property (@(posedge i_clk) disable iff (i_rst)
		((rd_go || wr_go) && !eq_ok) |=> !o_reply) else $error("reply without equipment match"); // R02
	a_data_reject: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_go && addr_ok && prot_ok && is_data && !data_q) |=> o_reject) else $error("empty read not rejected"); // R04
	a_prot_reject: assert property (@(posedge i_clk) disable iff (i_rst)
		(addressed && pn_s2.protect_sw && !pr_s2) |=> o_reject) else $error("unprotected access accepted"); // R20
	a_data_drop: assert property (@(posedge i_clk) disable iff (i_rst)
		(dat_acc && !col_in) |=> !data_q) else $error("data status held after transfer"); // R18
	a_lost_set: assert property (@(posedge i_clk) disable iff (i_rst)
		overrun |=> lost_q && !busy) else $error("overrun not flagged"); // R19
	// an accepted feed: busy and the transport pulse in the next cycle
	sequence s_feed_taken;
		f_feed;
	endsequence
	sequence s_feed_busy;
		busy && o_feed;
	endsequence
	a_busy_feed: assert property (@(posedge i_clk) disable iff (i_rst)
		s_feed_taken |=> s_feed_busy) else $error("feed did not set busy"); // R17
	a_alarm_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		((f_clr || f_clri) && !a_s2[F_ALMI]) |=> !almi_q && !almr_q) else $error("alarm interrupt not cleared"); // R11
	a_answer_excl: assert property (@(posedge i_clk) disable iff (i_rst)
		o_reply |-> !o_reject) else $error("reply and reject together"); // R25
	a_offset_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
		f_ofst |=> o_offset) else $error("offset request not passed on"); // R13
	a_alarm_resp: assert property (@(posedge i_clk) disable iff (i_rst)
		(almi_q && alarm && !f_clr && !f_clri) |=> almr_q) else $error("alarm response missing"); // R10
	a_clear_prio: assert property (@(posedge i_clk) disable iff (i_rst)
		(f_clr && a_s2[F_DATI]) |=> dati_q) else $error("clear beat request"); // R07
	a_ready_cond: assert property (@(posedge i_clk) disable iff (i_rst)
		!rdy_cond |=> !ready_q) else $error("ready without conditions"); // R16
endmodule : crp_channel_port

// *** crp_pkg.sv ***
// What this block does
// R01: converter field nonzero means ignore instruction
// R02: respond only on equipment switch match
// R03: read with director zero returns column
// R04: reject data read when nothing held
// R05: director write executes all set bits
// R06: not ready: clears only if bits 02-08 zero
// R07: clear bits yield to request bits
// R08: data interrupt while column available, reply drops
// R09: end interrupt only for later completions
// R10: alarm interrupt immediate or on detection
// R11: alarm enable and response clearing rules
// R12: feed starts card, prechecks, lost data
// R13: offset request; other bits ignored
// R14: status read level 1 or 2
// R15: level 1 status bit layout
// R16: ready needs all conditions, switch drops
// R17: busy from feed until end of operation
// R18: data status held until transfer
// R19: overrun sets lost data, ends card
// R20: protect switch rejects unprotected instructions
// R21: alarm ors not-ready and ready causes
// R22: pre-read error from light/dark check
// R23: ready alarms persist until clear
// R24: card ends at column 81; refeed silent
// R25: reply or reject for every addressed access
package crp_pkg;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned COL_W      = 12;
	localparam int unsigned Q_DIR0     = 0;
	localparam int unsigned Q_DIR1     = 1;
	localparam int unsigned Q_STA5     = 5;
	localparam int unsigned Q_STA6     = 6;
	localparam int unsigned Q_EQ_LO    = 7;
	localparam int unsigned Q_EQ_HI    = 10;
	localparam int unsigned Q_CV_LO    = 11;
	localparam int unsigned Q_CV_HI    = 15;
	localparam int unsigned F_CLR      = 0;
	localparam int unsigned F_CLRI     = 1;
	localparam int unsigned F_DATI     = 2;
	localparam int unsigned F_EOPI     = 3;
	localparam int unsigned F_ALMI     = 4;
	localparam int unsigned F_FEED     = 7;
	localparam int unsigned F_OFST     = 8;
	localparam int unsigned F_ACT_LO   = 2;
	localparam int unsigned F_ACT_HI   = 8;
	localparam int unsigned LAST_COL   = 80;
	localparam logic [WORD_W-1:0] ZERO_W = 16'h0000;

	typedef enum logic [2:0] {
		CRP_IDLE = 3'b001,
		CRP_READ = 3'b010,
		CRP_DONE = 3'b100
	} crp_state_e;

	typedef struct packed {
		logic power_ok;
		logic hopper_empty;
		logic stacker_full;
		logic jam;
		logic lid_open;
		logic fail_feed;
		logic read_jam;
		logic post_jam;
		logic stack_jam;
		logic end_of_file;
		logic manual;
		logic door_open;
		logic protect_sw;
		logic ready_sw;
	} crp_panel_s;

	typedef struct packed {
		logic             col_strobe;
		logic [COL_W-1:0] col_data;
		logic             card_in;
		logic             light_check;
		logic             dark_check;
		logic [COL_W-1:0] amp;
	} crp_station_s;
endpackage : crp_pkg

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
	import crp_pkg::*;
;
	localparam int unsigned NCOL = 4;
	localparam logic [1:0]  NONE = 2'h0;
	localparam logic [1:0]  RPLY = 2'h1;
	localparam logic [1:0]  RJCT = 2'h2;
	logic              i_clk, i_rst, i_read, i_write, i_prot;
	logic              o_reply, o_reject, o_interrupt, o_feed, o_offset;
	logic              feed_seen, ofs_seen;
	logic [WORD_W-1:0] i_q, i_a, o_a;
	logic [3:0]        eq;
	logic [COL_W-1:0]  col;
	crp_panel_s        i_panel;
	crp_station_s      i_station;
	int                n_fail, tests_run;

	initial i_clk = 1'b0;
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (o_feed) feed_seen <= 1'b1;
		if (o_offset) ofs_seen <= 1'b1;
	end

	crp_channel_port #(.COLS(NCOL)) u_crp_channel_port (.i_clk(i_clk), .i_rst(i_rst), .i_q(i_q), .i_a(i_a),
		.i_read(i_read), .i_write(i_write), .i_prot(i_prot), .i_equip_sw(eq), .i_panel(i_panel),
		.i_station(i_station), .o_a(o_a), .o_reply(o_reply), .o_reject(o_reject),
		.o_interrupt(o_interrupt), .o_feed(o_feed), .o_offset(o_offset));
	crp_channel_model u_crp_channel_model (.i_clk(i_clk), .i_a(o_a), .i_reply(o_reply), .i_reject(o_reject),
		.o_q(i_q), .o_a(i_a), .o_read(i_read), .o_write(i_write), .o_prot(i_prot));

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// converter field always zero on a legal command word
	function automatic logic [WORD_W-1:0] q_of(input logic d0, input logic d1, input logic [3:0] e);
		return {5'h00, e, 1'h0, 1'h1, 3'h0, d1, d0};
	endfunction : q_of

	task automatic op(input logic rd, input logic [WORD_W-1:0] q, input logic [WORD_W-1:0] a, input logic p,
		input logic [1:0] exp);
		u_crp_channel_model.xfer(rd, q, a, p);
		chk({14'h0000, u_crp_channel_model.resp}, {14'h0000, exp});
		if (exp != NONE && u_crp_channel_model.resp == NONE) end_of_test();
	endtask : op

	task automatic fn(input logic [WORD_W-1:0] a, input logic [1:0] exp);
		op(1'b0, q_of(1'b1, 1'b0, eq), a, 1'b0, exp);
	endtask : fn

	task automatic stat(input logic lvl, input logic [WORD_W-1:0] m, input logic [WORD_W-1:0] exp);
		op(1'b1, q_of(1'b1, lvl, eq), ZERO_W, 1'b0, RPLY);
		chk(u_crp_channel_model.data & m, exp);
	endtask : stat

	task automatic column(input logic [COL_W-1:0] d);
		@(negedge i_clk);
		i_station.col_data = d;
		i_station.amp = 12'($urandom);
		i_station.col_strobe = 1'b1;
		repeat (2) @(negedge i_clk);
		i_station.col_strobe = 1'b0;
		repeat (4) @(negedge i_clk);
	endtask : column

	initial begin
		void'($urandom(9));
		n_fail = 0;
		tests_run = 0;
		feed_seen = 1'b0;
		ofs_seen = 1'b0;
		i_rst = 1'b1;
		i_panel = '0;
		i_station = '0;
		i_panel.power_ok = 1'b1;
		i_panel.hopper_empty = 1'b1;
		eq = 4'($urandom);
		repeat (12) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (3) @(negedge i_clk);
		stat(1'b0, 16'h0001, 16'h0000);
		stat(1'b1, 16'h0001, 16'h0001);
		op(1'b1, q_of(1'b1, 1'b0, eq) | 16'h0800, ZERO_W, 1'b0, NONE);
		op(1'b1, q_of(1'b1, 1'b0, ~eq), ZERO_W, 1'b0, NONE);
		fn(16'h0001, RPLY);
		fn(16'h0003, RPLY);
		fn(16'h0005, RJCT);
		op(1'b1, q_of(1'b0, 1'b0, eq), ZERO_W, 1'b0, RJCT);
		$display("test not_ready done");
		i_panel.hopper_empty = 1'b0;
		i_panel.ready_sw = 1'b1;
		repeat (3) @(negedge i_clk);
		i_panel.ready_sw = 1'b0;
		stat(1'b0, 16'h0001, 16'h0001);
		i_panel.protect_sw = 1'b1;
		op(1'b1, q_of(1'b1, 1'b0, eq), ZERO_W, 1'b0, RJCT);
		op(1'b1, q_of(1'b1, 1'b0, eq), ZERO_W, 1'b1, RPLY);
		chk(u_crp_channel_model.data & 16'hF880, 16'h0080);
		i_panel.protect_sw = 1'b0;
		$display("test ready_protect done");
		fn(16'h008C, RPLY);
		chk({15'h0000, feed_seen}, 16'h0001);
		stat(1'b0, 16'h0002, 16'h0002);
		for (int k = 0; k < NCOL; k++) begin
			col = 12'($urandom);
			column(col);
			chk({15'h0000, o_interrupt}, 16'h0001);
			stat(1'b0, 16'h0008, 16'h0008);
			op(1'b1, q_of(1'b0, 1'b0, eq), ZERO_W, 1'b0, RPLY);
			chk(u_crp_channel_model.data, {4'h0, col});
			chk({15'h0000, o_interrupt}, 16'h0000);
		end
		column(12'($urandom));
		stat(1'b0, 16'h001A, 16'h0010);
		chk({15'h0000, o_interrupt}, 16'h0001);
		op(1'b1, q_of(1'b0, 1'b0, eq), ZERO_W, 1'b0, RJCT);
		fn(16'h0002, RPLY);
		chk({15'h0000, o_interrupt}, 16'h0000);
		$display("test card_read done");
		fn(16'h0080, RPLY);
		column(12'($urandom));
		column(12'($urandom));
		stat(1'b0, 16'h0062, 16'h0060);
		fn(16'h0008, RPLY);
		chk({15'h0000, o_interrupt}, 16'h0000);
		fn(16'h0010, RPLY);
		chk({15'h0000, o_interrupt}, 16'h0001);
		fn(16'h0002, RPLY);
		chk({15'h0000, o_interrupt}, 16'h0000);
		stat(1'b0, 16'h0040, 16'h0040);
		fn(16'h0001, RPLY);
		stat(1'b0, 16'h0060, 16'h0000);
		$display("test lost_data done");
		fn(16'h0100, RPLY);
		chk({15'h0000, ofs_seen}, 16'h0001);
		fn(16'h0020, RPLY);
		i_panel.stacker_full = 1'b1;
		stat(1'b0, 16'h0021, 16'h0020);
		op(1'b1, q_of(1'b0, 1'b0, eq), ZERO_W, 1'b0, RJCT);
		i_panel.stacker_full = 1'b0;
		stat(1'b0, 16'h0020, 16'h0000);
		$display("test alarm_offset done");
		end_of_test();
	end
endmodule : testbench
